// [rtl/eprom_programmer.sv]
// Host-side controller that reads, identifies and programs a UV EPROM through its pins.
// Assumes external level shifters turn the supply codes into Vcc/Vpp levels and
// drive the id select line to the identifier high voltage when asked.
`timescale 1ns/1ps
`default_nettype none
module eprom_programmer #(
   parameter int PULSE_CYC  = eprom_prog_pkg::PULSE_CYC,
   parameter int MAX_PULSES = eprom_prog_pkg::MAX_PULSES,
   parameter int WORDS      = eprom_prog_pkg::ARRAY_WORDS    // Bytes handled; smaller only for short runs
) (
   input  wire logic                               i_clk,
   input  wire logic                               i_rst,
   input  wire logic                               i_start,        // Command strobe
   input  wire logic [1:0]                         i_cmd,          // Command code
   input  wire logic [eprom_prog_pkg::ADDR_W-1:0]  i_addr,         // Read address
   input  wire logic                               i_img_we,       // Image write strobe
   input  wire logic [eprom_prog_pkg::ADDR_W-1:0]  i_img_addr,     // Image write address
   input  wire logic [eprom_prog_pkg::DATA_W-1:0]  i_img_data,     // Image write data
   input  wire logic [eprom_prog_pkg::DATA_W-1:0]  i_data_lines,   // Data pins from part
   output logic      [eprom_prog_pkg::ADDR_W-1:0]  o_addr_lines,   // Address pins
   output logic      [eprom_prog_pkg::DATA_W-1:0]  o_data_lines,   // Data pins to part
   output logic                                    o_data_oe,      // Drives data pins
   output logic                                    o_chip_enable_n,
   output logic                                    o_output_gate_n,
   output logic                                    o_program_strobe_n,
   output logic                                    o_id_high_voltage, // Force identifier level on id line
   output logic      [1:0]                         o_vcc_sel,
   output logic      [1:0]                         o_vpp_sel,
   output logic                                    o_busy,
   output logic                                    o_done,         // One-cycle completion pulse
   output logic                                    o_pass,
   output logic                                    o_fail,
   output logic      [eprom_prog_pkg::DATA_W-1:0]  o_rd_data,      // Read result
   output logic      [eprom_prog_pkg::DATA_W-1:0]  o_id_maker,     // Maker identifier
   output logic      [eprom_prog_pkg::DATA_W-1:0]  o_id_device,    // Device identifier
   output logic                                    o_id_parity_ok, // Both identifiers odd parity
   output logic      [eprom_prog_pkg::ADDR_W-1:0]  o_fail_addr
);
   localparam int AW = eprom_prog_pkg::ADDR_W;
   localparam int DW = eprom_prog_pkg::DATA_W;
   localparam int TW = 16;                                  // Timer width
   localparam logic [TW-1:0] T_PULSE  = TW'(PULSE_CYC);
   localparam logic [TW-1:0] T_SETTLE = TW'(eprom_prog_pkg::SETTLE_CYC);
   localparam logic [7:0]    P_MAX    = 8'(MAX_PULSES);
   localparam logic [AW-1:0] A_LAST   = AW'(WORDS - 1);

   // Controller states, one-hot
   typedef enum logic [9:0] {
      S_IDLE   = 10'h001,
      S_READ   = 10'h002,
      S_ID0    = 10'h004,
      S_ID1    = 10'h008,
      S_SETUP  = 10'h010,
      S_PULSE  = 10'h020,
      S_VERIFY = 10'h040,
      S_FINAL  = 10'h080,
      S_FCMP   = 10'h100,
      S_END    = 10'h200
   } state_t;

   // Odd parity check across a whole byte
   function automatic logic odd_parity(input logic [DW-1:0] b);
      odd_parity = ^b;
   endfunction : odd_parity

   // Two-flop synchroniser on the data pins
   logic [DW-1:0] din_meta;   // First stage, read only by din
   logic [DW-1:0] din;        // Synchronised data
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         din_meta <= eprom_prog_pkg::ERASED_BYTE;
         din      <= eprom_prog_pkg::ERASED_BYTE;
      end else begin
         din_meta <= i_data_lines;
         din      <= din_meta;
      end
   end

   // Image memory and its read address
   logic [DW-1:0] img_q;      // Registered image byte
   logic [AW-1:0] cur_addr;   // Address under work
   image_mem #(.AW(AW), .DW(DW)) u_img (
      .i_clk   (i_clk),
      .i_we    (i_img_we),
      .i_waddr (i_img_addr),
      .i_wdata (i_img_data),
      .i_raddr (cur_addr),
      .o_rdata (img_q)
   );

   state_t        state, next_state;
   logic [TW-1:0] timer, next_timer;          // Phase timer
   logic [7:0]    pulses, next_pulses;        // Pulses at this address
   logic [AW-1:0] next_cur_addr;
   logic [AW-1:0] addr_lines, next_addr_lines;
   logic [DW-1:0] dout, next_dout;
   logic          doe, next_doe;
   logic          ce_n, next_ce_n, og_n, next_og_n, ps_n, next_ps_n, idhv, next_idhv;
   logic [1:0]    vcc, next_vcc, vpp, next_vpp;
   logic          busy, next_busy, done, next_done, pass, next_pass, fail, next_fail;
   logic [DW-1:0] rd, next_rd, idm, next_idm, idd, next_idd;
   logic          idok, next_idok;
   logic [AW-1:0] faddr, next_faddr;
   logic          tdone;                      // Timer expired

   assign tdone = (timer == '0);

   // Next-state logic of the sequencer
   always_comb begin
      next_state = state; next_timer = (timer == '0) ? timer : timer - TW'(1);
      next_pulses = pulses; next_cur_addr = cur_addr; next_addr_lines = addr_lines;
      next_dout = dout; next_doe = doe; next_ce_n = ce_n; next_og_n = og_n;
      next_ps_n = ps_n; next_idhv = idhv; next_vcc = vcc; next_vpp = vpp;
      next_busy = busy; next_done = 1'b0; next_pass = pass; next_fail = fail;
      next_rd = rd; next_idm = idm; next_idd = idd; next_idok = idok; next_faddr = faddr;
      unique case (state)
         S_IDLE: begin
            // Chip enable high: part in standby, outputs off
            next_ce_n = 1'b1; next_og_n = 1'b1; next_ps_n = 1'b1; next_doe = 1'b0;
            next_idhv = 1'b0;
            next_vcc = eprom_prog_pkg::VCC_READ; next_vpp = eprom_prog_pkg::VPP_READ;
            if (i_start) begin
               next_busy = 1'b1; next_timer = T_SETTLE; next_ce_n = 1'b0;
               if (i_cmd == eprom_prog_pkg::CMD_READ) begin
                  // Chip and gate both low to read
                  next_addr_lines = i_addr; next_og_n = 1'b0; next_state = S_READ;
               end else if (i_cmd == eprom_prog_pkg::CMD_IDENT) begin
                  // Identifier voltage, other lines low, byte select low
                  next_addr_lines = '0; next_idhv = 1'b1; next_og_n = 1'b0;
                  next_state = S_ID0;
               end else if (i_cmd == eprom_prog_pkg::CMD_PROGRAM) begin
                  next_pass = 1'b0; next_fail = 1'b0; next_cur_addr = '0;
                  next_ce_n = 1'b1; next_state = S_SETUP;
               end else begin
                  next_busy = 1'b0; next_ce_n = 1'b1;
               end
            end
         end
         S_READ: if (tdone) begin
            next_rd = din; next_og_n = 1'b1; next_ce_n = 1'b1;
            next_busy = 1'b0; next_done = 1'b1; next_state = S_IDLE;
         end
         S_ID0: if (tdone) begin
            // Maker byte taken, move byte select high
            next_idm = din; next_addr_lines = AW'(1); next_timer = T_SETTLE; next_state = S_ID1;
         end
         S_ID1: if (tdone) begin
            next_idd = din;
            next_idok = odd_parity(idm) & odd_parity(din);
            next_idhv = 1'b0; next_og_n = 1'b1; next_ce_n = 1'b1; next_addr_lines = '0;
            next_busy = 1'b0; next_done = 1'b1; next_state = S_IDLE;
         end
         S_SETUP: begin
            // Program supplies, image byte on the data lines, chip selected
            next_vcc = eprom_prog_pkg::VCC_PROG; next_vpp = eprom_prog_pkg::VPP_PROG;
            next_addr_lines = cur_addr; next_og_n = 1'b1; next_ps_n = 1'b1;
            next_pulses = '0;
            if (tdone) begin
               next_dout = img_q; next_doe = 1'b1; next_ce_n = 1'b0; next_ps_n = 1'b0;
               next_pulses = 8'h01; next_timer = T_PULSE; next_state = S_PULSE;
            end
         end
         S_PULSE: if (tdone) begin
            // End pulse, release data, then verify with gate low and strobe high
            next_ps_n = 1'b1; next_doe = 1'b0; next_og_n = 1'b0;
            next_timer = T_SETTLE; next_state = S_VERIFY;
         end
         S_VERIFY: if (tdone) begin
            next_og_n = 1'b1;
            if (din == img_q) begin
               // Next address or final compare
               if (cur_addr == A_LAST) begin
                  next_cur_addr = '0; next_ce_n = 1'b1; next_timer = T_SETTLE; next_state = S_FINAL;
               end else begin
                  next_cur_addr = cur_addr + AW'(1); next_timer = T_SETTLE; next_state = S_SETUP;
               end
            end else if (pulses >= P_MAX) begin
               // Pulse limit reached: abort
               next_fail = 1'b1; next_faddr = cur_addr; next_ce_n = 1'b1; next_state = S_END;
            end else begin
               // Another pulse, byte only ever clears bits
               next_dout = img_q; next_doe = 1'b1; next_ps_n = 1'b0;
               next_pulses = pulses + 8'h01; next_timer = T_PULSE; next_state = S_PULSE;
            end
         end
         S_FINAL: begin
            // Final compare at reduced supplies
            next_vcc = eprom_prog_pkg::VCC_FINAL; next_vpp = eprom_prog_pkg::VPP_FINAL;
            next_addr_lines = cur_addr; next_ce_n = 1'b0; next_og_n = 1'b0;
            if (tdone) begin
               next_timer = T_SETTLE; next_state = S_FCMP;
            end
         end
         S_FCMP: if (tdone) begin
            if (din != img_q) begin
               next_fail = 1'b1; next_faddr = cur_addr; next_state = S_END;
            end else if (cur_addr == A_LAST) begin
               next_pass = 1'b1; next_state = S_END;
            end else begin
               next_cur_addr = cur_addr + AW'(1); next_timer = T_SETTLE; next_state = S_FINAL;
            end
         end
         S_END: begin
            next_ce_n = 1'b1; next_og_n = 1'b1; next_ps_n = 1'b1; next_doe = 1'b0;
            next_vcc = eprom_prog_pkg::VCC_READ; next_vpp = eprom_prog_pkg::VPP_READ;
            next_busy = 1'b0; next_done = 1'b1; next_state = S_IDLE;
         end
         default: next_state = S_IDLE;
      endcase
   end

   // Register the sequencer state
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= S_IDLE; timer <= '0; pulses <= '0; cur_addr <= '0; addr_lines <= '0;
         dout <= '0; doe <= 1'b0; ce_n <= 1'b1; og_n <= 1'b1; ps_n <= 1'b1; idhv <= 1'b0;
         vcc <= eprom_prog_pkg::VCC_READ; vpp <= eprom_prog_pkg::VPP_READ;
         busy <= 1'b0; done <= 1'b0; pass <= 1'b0; fail <= 1'b0;
         rd <= '0; idm <= '0; idd <= '0; idok <= 1'b0; faddr <= '0;
      end else begin
         state <= next_state; timer <= next_timer; pulses <= next_pulses; cur_addr <= next_cur_addr;
         addr_lines <= next_addr_lines; dout <= next_dout; doe <= next_doe; ce_n <= next_ce_n;
         og_n <= next_og_n; ps_n <= next_ps_n; idhv <= next_idhv; vcc <= next_vcc; vpp <= next_vpp;
         busy <= next_busy; done <= next_done; pass <= next_pass; fail <= next_fail;
         rd <= next_rd; idm <= next_idm; idd <= next_idd; idok <= next_idok; faddr <= next_faddr;
      end
   end

   assign o_addr_lines = addr_lines;  assign o_data_lines = dout;  assign o_data_oe = doe;
   assign o_chip_enable_n = ce_n;     assign o_output_gate_n = og_n; assign o_program_strobe_n = ps_n;
   assign o_id_high_voltage = idhv;   assign o_vcc_sel = vcc;      assign o_vpp_sel = vpp;
   assign o_busy = busy; assign o_done = done; assign o_pass = pass; assign o_fail = fail;
   assign o_rd_data = rd; assign o_id_maker = idm; assign o_id_device = idd;
   assign o_id_parity_ok = idok; assign o_fail_addr = faddr;

   // Checks
   property p_prog_levels;
      @(posedge i_clk) disable iff (i_rst)
      !ps_n |-> (!ce_n && vpp == eprom_prog_pkg::VPP_PROG && vcc == eprom_prog_pkg::VCC_PROG && doe);
   endproperty
   a_prog_levels: assert property (p_prog_levels) else $error("Pulse without program levels");
   property p_pulse_len;
      @(posedge i_clk) disable iff (i_rst)
      $fell(ps_n) |-> !ps_n [*8];
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("Pulse too short");
   property p_verify_mode;
      @(posedge i_clk) disable iff (i_rst)
      (state == S_VERIFY) |-> (!og_n || tdone) && ps_n && !doe && !ce_n;
   endproperty
   a_verify_mode: assert property (p_verify_mode) else $error("Bad verify levels");
   property p_no_drive_gate;
      @(posedge i_clk) disable iff (i_rst)
      doe |-> og_n;
   endproperty
   a_no_drive_gate: assert property (p_no_drive_gate) else $error("Contention on data lines");
   property p_final_levels;
      @(posedge i_clk) disable iff (i_rst)
      (state == S_FCMP) |-> (vcc == eprom_prog_pkg::VCC_FINAL && vpp == eprom_prog_pkg::VPP_FINAL);
   endproperty
   a_final_levels: assert property (p_final_levels) else $error("Final compare wrong supplies");
   property p_id_lines;
      @(posedge i_clk) disable iff (i_rst)
      idhv |-> (addr_lines[AW-1:1] == '0);
   endproperty
   a_id_lines: assert property (p_id_lines) else $error("Address lines high in identifier mode");
   property p_pulse_limit;
      @(posedge i_clk) disable iff (i_rst)
      pulses <= P_MAX;
   endproperty
   a_pulse_limit: assert property (p_pulse_limit) else $error("Too many pulses");
   property p_pass_fail;
      @(posedge i_clk) disable iff (i_rst)
      !(pass && fail);
   endproperty
   a_pass_fail: assert property (p_pass_fail) else $error("Pass and fail together");
   property p_idle_standby;
      @(posedge i_clk) disable iff (i_rst)
      (state == S_IDLE && !busy) |=> (ce_n || busy);
   endproperty
   a_idle_standby: assert property (p_idle_standby) else $error("Idle not in standby");
   c_read:  cover property (@(posedge i_clk) disable iff (i_rst) state == S_READ ##1 state == S_IDLE);
   c_ident: cover property (@(posedge i_clk) disable iff (i_rst) state == S_ID1 && tdone);
   c_retry: cover property (@(posedge i_clk) disable iff (i_rst) state == S_PULSE && pulses == 8'h02);
   c_pass:  cover property (@(posedge i_clk) disable iff (i_rst) $rose(pass));
endmodule : eprom_programmer
`default_nettype wire

// [shared/eprom_prog_pkg.sv]
// Constants shared by the EPROM programmer controller.
// Assumes a 100 MHz system clock and an external pin driver/level shifter.
package eprom_prog_pkg;
   localparam int ADDR_W            = 13;              // Address inputs of the part
   localparam int DATA_W            = 8;               // Byte-wide data lines
   localparam int ARRAY_WORDS       = 8192;            // Bytes in the array
   localparam int CLK_PERIOD_NS     = 10;              // 100 MHz clock
   localparam int PULSE_US          = 100;             // Programming pulse width
   localparam int PULSE_CYC         = (PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_NS         = 200;             // Access settle before sampling data
   localparam int SETTLE_CYC        = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MAX_PULSES        = 25;              // Pulse limit per address
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;  // Erased content reads all ones
   // Supply selection codes for the external regulators
   localparam logic [1:0] VCC_READ  = 2'h0;            // 5.0 V nominal
   localparam logic [1:0] VCC_PROG  = 2'h1;            // 6.25 V while pulsing
   localparam logic [1:0] VCC_FINAL = 2'h2;            // 5.25 V final compare
   localparam logic [1:0] VPP_READ  = 2'h0;            // Vpp at Vcc
   localparam logic [1:0] VPP_PROG  = 2'h1;            // 12.75 V programming level
   localparam logic [1:0] VPP_FINAL = 2'h2;            // 5.25 V final compare
   // Commands on the user port
   localparam logic [1:0] CMD_READ    = 2'h0;          // Single byte read
   localparam logic [1:0] CMD_PROGRAM = 2'h1;          // Program whole array from image
   localparam logic [1:0] CMD_IDENT   = 2'h2;          // Read both identifier bytes
endpackage : eprom_prog_pkg

// [rtl/image_mem.sv]
// Image memory holding the bytes to be written into the part.
// Assumes one write port from the user and one registered read port.
`timescale 1ns/1ps
`default_nettype none
module image_mem #(
   parameter int AW = 13,
   parameter int DW = 8
) (
   input  wire logic          i_clk,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [DW-1:0] i_wdata,
   input  wire logic [AW-1:0] i_raddr,
   output logic      [DW-1:0] o_rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];   // Storage array

   // Write and registered read
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule : image_mem
`default_nettype wire

// [test/eprom_part_model.sv]
// Behavioural model of the byte-wide UV-erasable memory part on the far side.
// Assumes the bench resolves the shared data lines and gives it the host clock.
`timescale 1ns/1ps
`default_nettype none
module eprom_part_model #(
   parameter logic [7:0] ID_MAKER  = 8'h2A,   // Arbitrary maker code, odd parity
   parameter logic [7:0] ID_DEVICE = 8'h8C    // Arbitrary device code, odd parity
) (
   input  wire logic        i_clk,
   input  wire logic [12:0] i_addr,           // Address pins
   input  wire logic [7:0]  i_dq_in,          // Data driven by the host
   input  wire logic        i_ce_n,
   input  wire logic        i_og_n,
   input  wire logic        i_ps_n,
   input  wire logic        i_id_hv,          // Identifier voltage on id select line
   input  wire logic [1:0]  i_vpp_sel,
   input  wire logic [12:0] i_hard_addr,      // Location that needs extra pulses
   input  wire logic [4:0]  i_hard_need,      // Pulses that location needs
   output logic      [7:0]  o_dq,             // Data seen by the host
   output logic             o_drive           // Part drives the data lines
);
   logic [7:0]  mem [0:8191];                 // Storage array
   logic        pgm;                          // Program condition present
   logic        pgm_q;                        // Program condition last cycle
   logic [12:0] a_q;                          // Address held over the pulse
   logic [7:0]  d_q;                          // Data held over the pulse
   logic [7:0]  last;                         // Last byte driven
   logic [7:0]  val;                          // Byte the part would drive
   int          hits;                         // Pulses seen at the hard location
   // Erased array reads all ones
   initial begin
      for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
      hits = 0;
      last = 8'h00;
      pgm_q = 1'b0;
   end
   // Only a selected part at program voltage takes a pulse
   assign pgm = !i_ce_n && !i_ps_n && (i_vpp_sel == eprom_prog_pkg::VPP_PROG);
   // Identifier bytes replace array data under the identifier voltage
   assign val = i_id_hv ? (i_addr[0] ? ID_DEVICE : ID_MAKER) : mem[i_addr];
   // Output gate and chip enable both low, not pulsing: drive data
   assign o_drive = !i_ce_n && !i_og_n && !pgm;
   // Released lines show the inverse of the last byte
   assign o_dq = o_drive ? val : ~last;
   // Pulse ends apply the byte; bits can only be cleared
   always @(posedge i_clk) begin
      if (o_drive) last = val;
      if (pgm_q && !pgm) begin
         if (a_q == i_hard_addr) hits = hits + 1;
         else hits = 0;
         if (a_q != i_hard_addr || hits >= int'(i_hard_need)) mem[a_q] = mem[a_q] & d_q;
      end
      if (pgm) begin
         a_q = i_addr;
         d_q = i_dq_in;
      end
      pgm_q = pgm;
   end
endmodule : eprom_part_model
`default_nettype wire

// [test/uv_eprom_mode_control_tb.sv]
// Self-checking bench for the programmer controller against the part model.
// Assumes the shared package is compiled first.
`timescale 1ns/1ps
`default_nettype none
module uv_eprom_mode_control_tb;
   localparam logic [7:0] MK = 8'h2A;         // Arbitrary maker code
   localparam logic [7:0] DV = 8'h8C;         // Arbitrary device code
   localparam int         NW = 256;           // Bytes programmed; a short array keeps the run brief
   logic i_clk, i_rst, start, we, oe, ce_n, og_n, ps_n, hv, busy, done, pass, fail, pok, drive;
   logic [1:0]  cmd, vcc, vpp;
   logic [12:0] addr, waddr, alines, faddr, hard_a, ra;
   logic [7:0]  wdata, dout, dq, bus, rd, idm, idd;
   logic [4:0]  need;
   logic [7:0]  img [0:8191];                 // Image written to the part
   logic [31:0] seed = 32'h150FE692;          // Fixed random seed
   int n_fail = 0;
   int check_count = 0;
   // Host data wins when the controller drives, else the part's lines
   assign bus = oe ? dout : dq;
   eprom_programmer #(.PULSE_CYC(10), .MAX_PULSES(3), .WORDS(NW)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_start(start),
      .i_cmd(cmd), .i_addr(addr), .i_img_we(we), .i_img_addr(waddr), .i_img_data(wdata), .i_data_lines(bus),
      .o_addr_lines(alines), .o_data_lines(dout), .o_data_oe(oe), .o_chip_enable_n(ce_n), .o_output_gate_n(og_n),
      .o_program_strobe_n(ps_n), .o_id_high_voltage(hv), .o_vcc_sel(vcc), .o_vpp_sel(vpp), .o_busy(busy),
      .o_done(done), .o_pass(pass), .o_fail(fail), .o_rd_data(rd), .o_id_maker(idm), .o_id_device(idd),
      .o_id_parity_ok(pok), .o_fail_addr(faddr));
   eprom_part_model #(.ID_MAKER(MK), .ID_DEVICE(DV)) part (.i_clk(i_clk), .i_addr(alines), .i_dq_in(dout),
      .i_ce_n(ce_n), .i_og_n(og_n), .i_ps_n(ps_n), .i_id_hv(hv), .i_vpp_sel(vpp), .i_hard_addr(hard_a),
      .i_hard_need(need), .o_dq(dq), .o_drive(drive));
   // Next random word
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Issue one command and wait for its completion pulse
   task automatic run(input logic [1:0] c, input logic [12:0] a);
      int n;
      @(posedge i_clk);
      start <= 1'b1;
      cmd   <= c;
      addr  <= a;
      @(posedge i_clk);
      start <= 1'b0;
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
      end while (done !== 1'b1 && n < 50000);
      if (n >= 50000) begin
         n_fail++;
         end_of_test();
      end
   endtask : run
   // Verdict
   task automatic end_of_test();
      $display("checks=%0d failures=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Hang guard, about twice the length of all scenarios
   initial begin
      #600000;
      n_fail++;
      end_of_test();
   end
   // Pin-level watch on every cycle
   always @(posedge i_clk) begin
      if (!i_rst) begin
         if (ps_n === 1'b0 && ce_n === 1'b0) begin
            check(vpp, eprom_prog_pkg::VPP_PROG);
            check(vcc, eprom_prog_pkg::VCC_PROG);
            check(oe, 1'b1);
         end
         if (hv === 1'b1) check(alines & 13'h1DFE, 13'h0000);
         if (oe === 1'b1) check(drive, 1'b0);
         if (og_n === 1'b0) check({ce_n, oe}, 2'b00);
         if (og_n === 1'b0 && vcc === eprom_prog_pkg::VCC_FINAL) check(vpp, eprom_prog_pkg::VPP_FINAL);
      end
   end
   // Main sequence
   initial begin
      i_rst = 1'b1; start = 1'b0; cmd = 2'h0; addr = '0; we = 1'b0; waddr = '0; wdata = '0;
      hard_a = 13'h1FFF; need = 5'h00;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      #1;
      check({ce_n, og_n, ps_n, oe, busy}, 5'h1C);
      @(posedge i_clk);
      start <= 1'b1;
      cmd   <= 2'h3;
      @(posedge i_clk);
      start <= 1'b0;
      repeat (3) @(posedge i_clk);
      #1;
      check({busy, ce_n}, 2'b01);
      run(eprom_prog_pkg::CMD_IDENT, 13'h0000);
      check(idm, MK);
      check(idd, DV);
      check(pok, 1'b1);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         run(eprom_prog_pkg::CMD_READ, seed[12:0]);
         check(rd, 8'hFF);
         check(busy, 1'b0);
      end
      // Locations past the programmed span stay erased
      for (int i = 0; i < 8192; i++) img[i] = 8'hFF;
      for (int i = 0; i < NW; i++) begin
         seed = xs(seed);
         img[i] = (i == 0 || i == NW - 1) ? 8'h00 : seed[7:0];
         @(posedge i_clk);
         we    <= 1'b1;
         waddr <= 13'(i);
         wdata <= img[i];
      end
      @(posedge i_clk);
      we     <= 1'b0;
      hard_a <= 13'h0000;
      need   <= 5'h1F;
      run(eprom_prog_pkg::CMD_PROGRAM, 13'h0000);
      check({pass, fail, faddr}, {2'b01, 13'h0000});
      hard_a <= 13'h0005;
      need   <= 5'h02;
      run(eprom_prog_pkg::CMD_PROGRAM, 13'h0000);
      check({pass, fail}, 2'b10);
      for (int i = 0; i < 10; i++) begin
         seed = xs(seed);
         ra = (i == 0) ? 13'h0005 : (i == 1) ? 13'h1FFF : (i == 2) ? 13'(NW - 1) : {5'h00, seed[7:0]};
         run(eprom_prog_pkg::CMD_READ, ra);
         check(rd, img[ra]);
      end
      end_of_test();
   end
endmodule : uv_eprom_mode_control_tb
`default_nettype wire
